// >>> rtl/acmk_dev.sv
// Purpose: device end: chaining modes, vector handling, key derivation
// Assumes: host drives the link on the same clock
// Notes:   direction bit is stored only; datapath encrypts
`timescale 1ns/1ps
`default_nettype none
`include "acmk_map.svh"
// Contract
// - Mode 01: keystream from prior output, XOR input
// - Feedback mode decrypts like encrypt, direction zero
// - Mode 10: XOR prior cipher, then encrypt
// - Software decrypts chaining via ECB plus XOR
// - No DMA or interrupt while vector select set
// - Feedback: vector replaced by new core output
// - Chaining: vector replaced by new cipher block
// - Vector flag cleared only by disable or write
// - Next blocks: write, start, wait, read only
// - Feedback setup follows fixed step order
// - Chaining setup same order, vector under select
// - Mode 11 run exposes round-10 key on data
// - Derived key read most significant byte first
// - Writing mode 11 clears key flag
// - Derive only after key loaded in mode 11
// - Other mode hides the derived key
// - Derivation steps: setup, key, data, start, read
// - Auto-start on sixteenth byte when flags ready
// - Disable clears key, vector and data flags
// - Done: busy falls, interrupt if enabled
// - DMA input when ready, output after completion
module acmk_dev
    import acmk_pkg::*;
(
    // Clock and reset
    input  wire logic SYS_CLK_I,
    input  wire logic RST_B_I,
    // Link to host
    acmk_if.dev       LINK,
    // User status
    output var  logic BUSY_O,
    output var  logic ERROR_O
);
    acmk_dev_st_t r, n;
    logic         core_done;
    logic [127:0] core_res;
    logic [127:0] core_rkey;
    logic [127:0] core_blk;
    logic         chain_now;

    // ----------------------------------------
    // Core input selection
    // ----------------------------------------
    always_comb begin
        unique case (r.mode)
            ACMK_OFB: core_blk = r.iv;
            ACMK_CBC: core_blk = r.data ^ r.iv;
            default:  core_blk = r.data;
        endcase
    end

    assign chain_now = (r.mode == ACMK_OFB) || (r.mode == ACMK_CBC);

    acmk_core u_core (
        .clk_i   (SYS_CLK_I),
        .rst_b_i (RST_B_I),
        .start_i (r.go),
        .key_i   (r.key),
        .block_i (core_blk),
        .done_o  (core_done),
        .result_o(core_res),
        .rkey_o  (core_rkey)
    );

    // ----------------------------------------
    // Register and sequencing logic
    // ----------------------------------------
    always_comb begin
        n = r;
        n.go = 1'b0;
        n.irq = 1'b0;
        if (LINK.wr) begin
            unique case (LINK.addr)
                `ACMK_A_CTRL: begin
                    n.en    = LINK.wdata[`ACMK_C_EN];
                    n.mode  = acmk_mode_t'(LINK.wdata[`ACMK_C_MODE_HI:`ACMK_C_MODE_LO]);
                    n.dec   = LINK.wdata[`ACMK_C_DEC];
                    n.aoff  = LINK.wdata[`ACMK_C_AOFF];
                    n.irqen = LINK.wdata[`ACMK_C_IRQEN];
                    n.ivsel = LINK.wdata[`ACMK_C_IVSEL];
                    if (n.mode == ACMK_KDRV) n.kld = 1'b0;
                    if (r.mode == ACMK_KDRV && n.mode != ACMK_KDRV) begin
                        n.out = '0;
                        n.txpend = 1'b0;
                    end
                end
                `ACMK_A_STAT: begin
                    if (LINK.wdata[`ACMK_S_ERR]) n.err = 1'b0;
                    if (LINK.wdata[`ACMK_S_BUSY] && !r.busy) begin
                        n.busy = 1'b1;
                        n.go = 1'b1;
                    end
                end
                `ACMK_A_KEY: begin
                    if (r.busy) begin
                        n.err = 1'b1;
                    end else begin
                        n.key = {r.key[119:0], LINK.wdata};
                        n.kld = 1'b0;
                        n.kcnt = r.kcnt + 4'h1;
                        if (r.kcnt == `ACMK_LAST_BYTE) n.kld = 1'b1;
                    end
                end
                default: begin
                    if (r.busy) begin
                        n.err = 1'b1;
                    end else if (r.ivsel) begin
                        n.iv = {r.iv[119:0], LINK.wdata};
                        n.vector_loaded_flag = 1'b0;
                        n.icnt = r.icnt + 4'h1;
                        if (r.icnt == `ACMK_LAST_BYTE) n.vector_loaded_flag = 1'b1;
                    end else begin
                        n.data = {r.data[119:0], LINK.wdata};
                        n.dld = 1'b0;
                        n.dcnt = r.dcnt + 4'h1;
                        if (r.dcnt == `ACMK_LAST_BYTE) begin
                            n.dld = 1'b1;
                            if (!r.aoff && r.kld && (r.vector_loaded_flag || !chain_now)) begin
                                n.busy = 1'b1;
                                n.go = 1'b1;
                            end
                        end
                    end
                end
            endcase
        end

        // Reads: data port shifts out, most significant byte first
        if (LINK.rd) begin
            unique case (LINK.addr)
                `ACMK_A_CTRL: n.rdata = {1'b0, r.ivsel, r.irqen, r.aoff, r.dec,
                                          r.mode, r.en};
                `ACMK_A_STAT: n.rdata = {3'h0, r.dld, r.vector_loaded_flag, r.kld, r.err, r.busy};
                `ACMK_A_KEY:  n.rdata = 8'h00;
                default: begin
                    n.rdata = 8'h00;
                    if (!r.ivsel && !r.busy) begin
                        n.rdata = r.out[127:120];
                        n.out = {r.out[119:0], 8'h00};
                        n.rcnt = r.rcnt + 4'h1;
                        if (r.rcnt == `ACMK_LAST_BYTE) n.txpend = 1'b0;
                    end
                end
            endcase
        end

        // Completion of one block
        if (core_done) begin
            n.busy = 1'b0;
            n.dld = 1'b0;
            n.dcnt = 4'h0;
            n.rcnt = 4'h0;
            n.txpend = 1'b1;
            n.irq = r.irqen && !r.ivsel;
            unique case (r.mode)
                ACMK_OFB: begin
                    n.out = r.data ^ core_res;
                    n.iv = core_res;
                end
                ACMK_CBC: begin
                    n.out = core_res;
                    n.iv = core_res;
                end
                ACMK_KDRV: n.out = r.kld ? core_rkey : '0;
                default:   n.out = core_res;
            endcase
        end

        // Disable drops all load flags
        if (!n.en) begin
            n.kld = 1'b0;
            n.vector_loaded_flag = 1'b0;
            n.dld = 1'b0;
            n.kcnt = 4'h0;
            n.icnt = 4'h0;
            n.dcnt = 4'h0;
            n.txpend = 1'b0;
        end

        n.dmain = n.en && n.kld && !n.dld && !n.busy && !n.txpend && !n.ivsel
                  && (n.vector_loaded_flag || !(n.mode inside {ACMK_OFB, ACMK_CBC}));
        n.dmaout = n.en && n.txpend && !n.ivsel;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) r <= '0;
        else r <= n;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign LINK.rdata = r.rdata;
    assign LINK.dma_input_request = r.dmain;
    assign LINK.dma_output_request = r.dmaout;
    assign LINK.done_irq = r.irq;
    assign BUSY_O = r.busy;
    assign ERROR_O = r.err;
endmodule // acmk_dev
`default_nettype wire

// >>> rtl/acmk_map.svh
// Purpose: offsets, bit positions and counts of the chaining block
// Assumes: byte-wide link, AXI4-Lite word map on the host end
// Notes:   definitions only
`ifndef ACMK_MAP_SVH
`define ACMK_MAP_SVH
// ----------------------------------------
// Link byte addresses
// ----------------------------------------
`define ACMK_A_DATA 2'h0
`define ACMK_A_KEY 2'h1
`define ACMK_A_CTRL 2'h2
`define ACMK_A_STAT 2'h3
// ----------------------------------------
// Control and status bits
// ----------------------------------------
`define ACMK_C_EN 0
`define ACMK_C_MODE_LO 1
`define ACMK_C_MODE_HI 2
`define ACMK_C_DEC 3
`define ACMK_C_AOFF 4
`define ACMK_C_IRQEN 5
`define ACMK_C_IVSEL 6
`define ACMK_S_BUSY 0
`define ACMK_S_ERR 1
`define ACMK_S_KLD 2
`define ACMK_S_VECTOR_LOADED_FLAG 3
`define ACMK_S_DLD 4
// ----------------------------------------
// Counts and constants
// ----------------------------------------
`define ACMK_LAST_BYTE 4'hF
`define ACMK_ROUNDS 4'hA
`define ACMK_RCON0 8'h01
`define ACMK_POLY 8'h1B
`define ACMK_AFF 8'h63
// ----------------------------------------
// Host AXI4-Lite word offsets
// ----------------------------------------
`define ACMK_X_DATA 5'h00
`define ACMK_X_KEY 5'h04
`define ACMK_X_CTRL 5'h08
`define ACMK_X_STAT 5'h0C
`define ACMK_X_LINK 5'h10
`define ACMK_RESP_OK 2'h0
`define ACMK_RESP_ERR 2'h2
`endif

// >>> rtl/acmk_pkg.sv
// Purpose: types of the chaining block
// Assumes: nothing
// Notes:   mode codes follow the enum order
package acmk_pkg;
    typedef enum logic [1:0] {ACMK_ECB, ACMK_OFB, ACMK_CBC, ACMK_KDRV} acmk_mode_t;
    typedef enum logic {CORE_IDLE, CORE_RUN} acmk_core_ph_t;
    typedef enum logic [1:0] {H_IDLE, H_RD, H_RCAP} acmk_host_ph_t;
    typedef struct packed {
        acmk_core_ph_t ph;
        logic [3:0]    rnd;
        logic [7:0]    rcon;
        logic [127:0]  st;
        logic [127:0]  rk;
        logic          done;
    } acmk_core_st_t;
    typedef struct packed {
        logic         en;
        acmk_mode_t   mode;
        logic         dec;
        logic         aoff;
        logic         irqen;
        logic         ivsel;
        logic         busy;
        logic         err;
        logic         kld;
        logic         vector_loaded_flag;
        logic         dld;
        logic         txpend;
        logic [3:0]   kcnt;
        logic [3:0]   icnt;
        logic [3:0]   dcnt;
        logic [3:0]   rcnt;
        logic [127:0] key;
        logic [127:0] iv;
        logic [127:0] data;
        logic [127:0] out;
        logic [7:0]   rdata;
        logic         go;
        logic         dmain;
        logic         dmaout;
        logic         irq;
    } acmk_dev_st_t;
    typedef struct packed {
        acmk_host_ph_t ph;
        logic          aw_ok;
        logic          w_ok;
        logic          ar_ok;
        logic [4:0]    awaddr;
        logic [4:0]    araddr;
        logic [7:0]    wbyte;
        logic          awready;
        logic          wready;
        logic          arready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [1:0]    rresp;
        logic [31:0]   rdata;
        logic          wr;
        logic          rd;
        logic [1:0]    addr;
        logic          done_seen;
    } acmk_host_st_t;
endpackage

// >>> rtl/acmk_if.sv
// Purpose: byte-wide register link between host end and device end
// Assumes: both ends on one clock
// Notes:   rdata answers one cycle after rd
`timescale 1ns/1ps
`default_nettype none
interface acmk_if;
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       dma_input_request;
    logic       dma_output_request;
    logic       done_irq;
    modport dev (input wr, rd, addr, wdata,
                 output rdata, dma_input_request, dma_output_request, done_irq);
    modport host (output wr, rd, addr, wdata,
                  input rdata, dma_input_request, dma_output_request, done_irq);
endinterface
`default_nettype wire

// >>> rtl/acmk_core.sv
// Purpose: iterative AES-128 encrypt core, one round per clock
// Assumes: start only while idle
// Notes:   rkey_o holds the round-10 key after done
`timescale 1ns/1ps
`default_nettype none
`include "acmk_map.svh"
module acmk_core
    import acmk_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // Job
    input  wire logic         start_i,
    input  wire logic [127:0] key_i,
    input  wire logic [127:0] block_i,
    // Result
    output var  logic         done_o,
    output var  logic [127:0] result_o,
    output var  logic [127:0] rkey_o
);
    acmk_core_st_t r, n;

    function automatic logic [7:0] xt(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? `ACMK_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = xt(x);
        end
        return p;
    endfunction

    // Inverse as x^254, then affine map
    function automatic logic [7:0] sbox(input logic [7:0] a);
        logic [7:0] q;
        logic [7:0] y;
        q = a;
        y = 8'h01;
        for (int k = 1; k < 8; k++) begin
            q = gmul(q, q);
            y = gmul(y, q);
        end
        return y ^ {y[6:0], y[7]} ^ {y[5:0], y[7:6]} ^ {y[4:0], y[7:5]}
                 ^ {y[3:0], y[7:4]} ^ `ACMK_AFF;
    endfunction

    function automatic logic [127:0] kexp(input logic [127:0] k, input logic [7:0] rc);
        logic [31:0] t;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] w2;
        t = {sbox(k[23:16]), sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])} ^ {rc, 24'h0};
        w0 = k[127:96] ^ t;
        w1 = k[95:64] ^ w0;
        w2 = k[63:32] ^ w1;
        return {w0, w1, w2, k[31:0] ^ w2};
    endfunction

    // Byte i is state (i%4, i/4), byte 0 in the top bits
    function automatic logic [127:0] rnd_f(input logic [127:0] s, input logic [127:0] k,
                                           input logic last);
        logic [7:0]   b [16];
        logic [7:0]   t [16];
        logic [127:0] o;
        for (int i = 0; i < 16; i++) b[i] = sbox(s[127-8*i -: 8]);
        for (int c = 0; c < 4; c++)
            for (int w = 0; w < 4; w++) t[4*c+w] = b[4*((c+w)%4)+w];
        for (int c = 0; c < 4; c++) begin
            if (last) begin
                o[127-32*c -: 32] = {t[4*c], t[4*c+1], t[4*c+2], t[4*c+3]};
            end else begin
                o[127-32*c -: 8] = xt(t[4*c]) ^ xt(t[4*c+1]) ^ t[4*c+1] ^ t[4*c+2] ^ t[4*c+3];
                o[119-32*c -: 8] = t[4*c] ^ xt(t[4*c+1]) ^ xt(t[4*c+2]) ^ t[4*c+2] ^ t[4*c+3];
                o[111-32*c -: 8] = t[4*c] ^ t[4*c+1] ^ xt(t[4*c+2]) ^ xt(t[4*c+3]) ^ t[4*c+3];
                o[103-32*c -: 8] = xt(t[4*c]) ^ t[4*c] ^ t[4*c+1] ^ t[4*c+2] ^ xt(t[4*c+3]);
            end
        end
        return o ^ k;
    endfunction

    // ----------------------------------------
    // Round engine
    // ----------------------------------------
    always_comb begin
        logic [127:0] nk;
        nk = kexp(r.rk, r.rcon);
        n = r;
        n.done = 1'b0;
        unique case (r.ph)
            CORE_IDLE: begin
                if (start_i) begin
                    n.ph = CORE_RUN;
                    n.st = block_i ^ key_i;
                    n.rk = key_i;
                    n.rnd = 4'h1;
                    n.rcon = `ACMK_RCON0;
                end
            end
            CORE_RUN: begin
                n.st = rnd_f(r.st, nk, r.rnd == `ACMK_ROUNDS);
                n.rk = nk;
                n.rcon = xt(r.rcon);
                n.rnd = r.rnd + 4'h1;
                if (r.rnd == `ACMK_ROUNDS) begin
                    n.ph = CORE_IDLE;
                    n.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) r <= '0;
        else r <= n;
    end

    assign done_o = r.done;
    assign result_o = r.st;
    assign rkey_o = r.rk;
endmodule // acmk_core
`default_nettype wire

// >>> rtl/acmk_host.sv
// Purpose: host end: AXI4-Lite slave turned into byte accesses on the link
// Assumes: one write and one read in flight at most
// Notes:   words carry the byte in bits 7:0
`timescale 1ns/1ps
`default_nettype none
`include "acmk_map.svh"
module acmk_host
    import acmk_pkg::*;
(
    // Clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_B_I,
    // AXI4-Lite write
    input  wire logic [4:0]  AWADDR_I,
    input  wire logic        AWVALID_I,
    output var  logic        AWREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    input  wire logic        WVALID_I,
    output var  logic        WREADY_O,
    output var  logic [1:0]  BRESP_O,
    output var  logic        BVALID_O,
    input  wire logic        BREADY_I,
    // AXI4-Lite read
    input  wire logic [4:0]  ARADDR_I,
    input  wire logic        ARVALID_I,
    output var  logic        ARREADY_O,
    output var  logic [31:0] RDATA_O,
    output var  logic [1:0]  RRESP_O,
    output var  logic        RVALID_O,
    input  wire logic        RREADY_I,
    // Link to device
    acmk_if.host             LINK
);
    acmk_host_st_t r, n;
    logic          wmap;
    logic          rmap;

    assign wmap = (r.awaddr[1:0] == 2'h0) && (r.awaddr[4:2] < 3'h4);
    assign rmap = (r.araddr[1:0] == 2'h0) && (r.araddr[4:2] < 3'h4);

    // ----------------------------------------
    // Channel handling and link sequencing
    // ----------------------------------------
    always_comb begin
        n = r;
        n.wr = 1'b0;
        n.rd = 1'b0;
        if (AWVALID_I && r.awready) begin
            n.aw_ok = 1'b1;
            n.awaddr = AWADDR_I;
        end
        if (WVALID_I && r.wready) begin
            n.w_ok = 1'b1;
            n.wbyte = WSTRB_I[0] ? WDATA_I[7:0] : 8'h00;
        end
        if (ARVALID_I && r.arready) begin
            n.ar_ok = 1'b1;
            n.araddr = ARADDR_I;
        end
        if (BREADY_I && r.bvalid) n.bvalid = 1'b0;
        if (RREADY_I && r.rvalid) n.rvalid = 1'b0;
        if (LINK.done_irq) n.done_seen = 1'b1;
        unique case (r.ph)
            H_IDLE: begin
                if (r.aw_ok && r.w_ok && !r.bvalid) begin
                    // Bytes pass in bus order; software sequences them
                    n.wr = wmap;
                    n.addr = r.awaddr[3:2];
                    if (r.awaddr == `ACMK_X_CTRL &&
                        r.wbyte[`ACMK_C_MODE_HI:`ACMK_C_MODE_LO] == 2'h1)
                        n.wbyte[`ACMK_C_DEC] = 1'b0;
                    n.bresp = (wmap || r.awaddr == `ACMK_X_LINK) ? `ACMK_RESP_OK
                                                                  : `ACMK_RESP_ERR;
                    n.bvalid = 1'b1;
                    n.aw_ok = 1'b0;
                    n.w_ok = 1'b0;
                end else if (r.ar_ok && !r.rvalid) begin
                    n.ar_ok = 1'b0;
                    if (rmap) begin
                        n.rd = 1'b1;
                        n.addr = r.araddr[3:2];
                        n.ph = H_RD;
                    end else begin
                        n.rvalid = 1'b1;
                        n.rdata = '0;
                        n.rresp = `ACMK_RESP_ERR;
                        if (r.araddr == `ACMK_X_LINK) begin
                            n.rresp = `ACMK_RESP_OK;
                            n.rdata = {29'h0, r.done_seen, LINK.dma_output_request,
                                       LINK.dma_input_request};
                            n.done_seen = LINK.done_irq;
                        end
                    end
                end
            end
            H_RD: n.ph = H_RCAP;
            H_RCAP: begin
                n.rdata = {24'h0, LINK.rdata};
                n.rresp = `ACMK_RESP_OK;
                n.rvalid = 1'b1;
                n.ph = H_IDLE;
            end
            default: n.ph = H_IDLE;
        endcase
        n.awready = !n.aw_ok && !n.bvalid && !(AWVALID_I && r.awready);
        n.wready = !n.w_ok && !n.bvalid && !(WVALID_I && r.wready);
        n.arready = !n.ar_ok && !n.rvalid && (n.ph == H_IDLE) && !(ARVALID_I && r.arready);
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) r <= '0;
        else r <= n;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign AWREADY_O = r.awready;
    assign WREADY_O = r.wready;
    assign BRESP_O = r.bresp;
    assign BVALID_O = r.bvalid;
    assign ARREADY_O = r.arready;
    assign RDATA_O = r.rdata;
    assign RRESP_O = r.rresp;
    assign RVALID_O = r.rvalid;
    assign LINK.wr = r.wr;
    assign LINK.rd = r.rd;
    assign LINK.addr = r.addr;
    assign LINK.wdata = r.wbyte;
endmodule // acmk_host
`default_nettype wire

// >>> test/acmk_monitor.sv
// Purpose: link checker for the chaining block
// Assumes: one clock, synchronous active-low reset
// Notes:   watches the link signals only
`timescale 1ns/1ps
`default_nettype none
module acmk_monitor (
    input wire logic       SYS_CLK_I,
    input wire logic       RST_B_I,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       dma_input_request,
    input wire logic       dma_output_request,
    input wire logic       done_irq
);
    // ----
    // Shadow of control byte and key writes
    // ----
    logic [7:0] ctl_r;
    logic       kw_r;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            ctl_r <= 8'h00;
            kw_r  <= 1'b0;
        end else if (wr && addr == 2'h2) begin
            ctl_r <= wdata;
            if (wdata[2:1] == 2'h3) kw_r <= 1'b0;
        end else if (wr && addr == 2'h1) begin
            kw_r <= 1'b1;
        end
    end
    sequence s_stat_rd; rd && addr == 2'h3; endsequence
    property p_irq_pulse; done_irq |=> !done_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too wide");
    property p_irq_cause; done_irq |-> $past(wr && (addr == 2'h0 || addr == 2'h3), 13); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without start");
    property p_irq_en; done_irq |-> $past(ctl_r[5] && !ctl_r[6]); endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq while masked");
    property p_quiet; ctl_r[6] [*3] |-> !(dma_input_request || dma_output_request); endproperty
    a_quiet: assert property (p_quiet) else $error("request under vector select");
    property p_rd_hold; !$past(rd) |-> $stable(rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read byte moved");
    property p_dout; $rose(dma_output_request) && !$past(ctl_r[6], 2) |->
        $past(wr && (addr == 2'h0 || addr == 2'h3), 13); endproperty
    a_dout: assert property (p_dout) else $error("output request early");
    property p_excl; dma_output_request |-> !dma_input_request; endproperty
    a_excl: assert property (p_excl) else $error("both requests");
    property p_din_en; !ctl_r[0] [*3] |-> !dma_input_request; endproperty
    a_din_en: assert property (p_din_en) else $error("input request disabled");
    property p_key_clr; s_stat_rd ##0 (ctl_r[2:1] == 2'h3 && !kw_r) |=> !rdata[2]; endproperty
    a_key_clr: assert property (p_key_clr) else $error("key flag kept");
endmodule // acmk_monitor
`default_nettype wire

// >>> test/tb.sv
// Purpose: bench for both ends over AXI4-Lite
// Assumes: 25 MHz clock
// Notes:   AES-128 known-answer vectors
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0, rst_b = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    wire  logic  awr, wrd, bv, arr, rv, err, bsy;
    wire  logic [1:0]  rresp, bresp;
    wire  logic [31:0] rdata;
    int          fail_count = 0, num_checks = 0;
    logic [33:0] r;
    logic [127:0] q;
    localparam logic [127:0] K = 128'h000102030405060708090A0B0C0D0E0F;
    localparam logic [127:0] P = 128'h00112233445566778899AABBCCDDEEFF;
    localparam logic [127:0] C = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    localparam logic [127:0] RK = 128'h13111D7FE3944A17F307A78B4D2B30C5;
    acmk_if lnk ();
    always #20 clk = ~clk;
    acmk_host u_acmk_host (.SYS_CLK_I(clk), .RST_B_I(rst_b), .AWADDR_I(awaddr), .AWVALID_I(awv),
        .AWREADY_O(awr), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wv), .WREADY_O(wrd),
        .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(bre), .ARADDR_I(araddr), .ARVALID_I(arv),
        .ARREADY_O(arr), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rre),
        .LINK(lnk));
    acmk_dev u_acmk_dev (.SYS_CLK_I(clk), .RST_B_I(rst_b), .LINK(lnk), .BUSY_O(bsy),
        .ERROR_O(err));
    acmk_monitor u_acmk_monitor (.SYS_CLK_I(clk), .RST_B_I(rst_b), .wr(lnk.wr), .rd(lnk.rd),
        .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
        .dma_input_request(lnk.dma_input_request),
        .dma_output_request(lnk.dma_output_request), .done_irq(lnk.done_irq));
    // ----
    // Bus tasks
    // ----
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 60) begin
            fail_count++;
            results();
        end
    endtask
    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; awv <= 1; wv <= 1; bre <= 1;
        do begin
            @(posedge clk);
            n++;
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
        end while (!bv && n < 60);
        r[33:32] = bresp;
        bre <= 0;
        tmo(n);
    endtask
    task automatic rd(input logic [4:0] a);
        int n = 0;
        @(posedge clk);
        araddr <= a; arv <= 1; rre <= 1;
        do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 0;
        end while (!rv && n < 60);
        r = {rresp, rdata};
        rre <= 0;
        tmo(n);
    endtask
    task automatic put16(input logic [4:0] a, input logic [127:0] v);
        for (int i = 15; i >= 0; i--) wr(a, v[8*i +: 8]);
    endtask
    task automatic get16();
        for (int i = 15; i >= 0; i--) begin
            rd(5'h00);
            q[8*i +: 8] = r[7:0];
        end
    endtask
    task automatic go();
        int n = 0;
        wr(5'h0C, 8'h01);
        do begin
            rd(5'h0C);
            n++;
        end while (r[0] && n < 60);
        tmo(n);
    endtask
    task automatic t_chain(input logic [7:0] c, input logic [127:0] d, input logic [127:0] e);
        wr(5'h08, c); put16(5'h04, K); wr(5'h08, c | 8'h40); put16(5'h00, P); wr(5'h08, c);
        rd(5'h0C); chk("flags", 128'h0C, 128'(r[7:0]));
        put16(5'h00, d); go(); get16(); chk("block", e, q);
        wr(5'h08, 8'h25); put16(5'h00, C ^ P);
        rd(5'h0C); chk("auto", 128'h1, 128'(r[0]));
        go(); rd(5'h10); chk("link", 128'h6, 128'(r[7:0]));
        get16(); chk("chained", C, q);
        rd(5'h0C); chk("vector kept", 128'h0C, 128'(r[7:0]));
        $display("chain mode %h done", c[2:1]);
    endtask
    task automatic t_kdrv();
        wr(5'h08, 8'h17); rd(5'h0C); chk("key flag", 128'h0, 128'(r[2]));
        put16(5'h00, P); go(); get16(); chk("no key", 128'h0, q);
        put16(5'h04, K); put16(5'h00, P); go(); get16(); chk("round key", RK, q);
        go(); wr(5'h08, 8'h11); get16(); chk("hidden", 128'h0, q);
        put16(5'h00, P); go(); get16(); chk("ecb", C, q);
        $display("derive done");
    endtask
    task automatic t_misc();
        wr(5'h08, 8'h75); wr(5'h00, 8'h00); rd(5'h0C); chk("vec clr", 128'h04, 128'(r[7:0]));
        wr(5'h08, 8'h00); rd(5'h0C); chk("disable", 128'h0, 128'(r[7:0]));
        rd(5'h14); chk("unmapped", 128'h2, 128'(r[33:32]));
        wr(5'h14, 8'h00); chk("wr unmapped", 128'h2, 128'(r[33:32]));
        wr(5'h0C, 8'h01); wr(5'h04, 8'h00); rd(5'h0C);
        chk("busy err", 128'hF, 128'({r[1:0], err, bsy}));
        $display("misc done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_chain(8'h35, 128'h0, C);
        t_chain(8'h33, C, 128'h0);
        t_kdrv();
        t_misc();
        results();
    end
endmodule // tb
`default_nettype wire
